// [tdcc_ctrl.sv]
// Calibration and control register with its serial port and pin logic.
// Summary of operation
// - Bit 9 enables the active-low interrupt pin; all sources OR onto it.
// - Bit 8 cleared: event command runs a single measurement sequence.
// - Bit 7 set: interrupt after every measurement cycle if pin enabled.
// - Bit 7 cleared: interrupt timing follows only the continuous bit.
// - Bits 6:4 codes 0,1,2 wait 16, 48, 96 slow-clock periods.
// - Codes 3,4 wait 128, 168 periods; codes 5 to 7 keep oscillator on.
// - Monitor disabled drives the pin low; enabled, the selected source.
// - Bits 3:0: calibration window is field plus one slow-clock periods.
`include "tdcc_defines.svh"
`timescale 1ns/1ps
module tdcc_ctrl (
    input  wire logic mclk,
    input  wire logic nrst,
    input  wire logic spi_sclk,
    input  wire logic spi_cs_n,
    input  wire logic spi_mosi,
    output logic      spi_miso,
    output logic      spi_miso_oe_n,
    input  wire logic clk32k,
    input  wire logic comparator_in,
    input  wire logic launch_dir_in,
    output logic      monitor_out_pin,
    input  wire logic evt_running,
    input  wire logic cycle_done,
    input  wire logic seq_done,
    input  wire logic irq_other,
    input  wire logic irq_clear,
    output logic      int_n,
    output logic      evt_halt,
    output logic      evt_repeat,
    input  wire logic osc_request,
    output logic      osc_enable,
    output logic      osc_ready,
    input  wire logic cal_start,
    output logic      cal_window
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    // ------------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------------
    logic [5:0] raw_in;
    logic [5:0] syn;
    logic       sclk_s, cs_n_s, mosi_s, cmp_s, dir_s, slow_s;
    logic       sclk_d, slow_d;
    assign raw_in = {spi_sclk, spi_cs_n, spi_mosi,
                     comparator_in, launch_dir_in, clk32k};
    assign {sclk_s, cs_n_s, mosi_s, cmp_s, dir_s, slow_s} = syn;
    tdcc_sync2 #(.W(6)) u_sync (
        .mclk (mclk),
        .nrst (nrst),
        .d    (raw_in),
        .q    (syn)
    );
    logic sclk_rise, sclk_fall, tick32;
    assign sclk_rise = sclk_s & ~sclk_d & ~cs_n_s;
    assign sclk_fall = ~sclk_s & sclk_d & ~cs_n_s;
    assign tick32    = slow_s & ~slow_d;

    // ------------------------------------------------------------------
    // Serial register access
    // ------------------------------------------------------------------
    tdcc_pkg::tdcc_ctrl_t ctrl, next_ctrl;
    tdcc_pkg::tdcc_spi_t  spi_st, next_spi_st;
    logic [4:0]  bit_cnt, next_bit_cnt;
    logic [15:0] sh_in, next_sh_in;
    logic [15:0] sh_out, next_sh_out;
    logic        next_miso, next_miso_oe_n;
    always_comb begin
        next_ctrl      = ctrl;
        next_spi_st    = spi_st;
        next_bit_cnt   = bit_cnt;
        next_sh_in     = sh_in;
        next_sh_out    = sh_out;
        next_miso      = spi_miso;
        next_miso_oe_n = ~(spi_st == tdcc_pkg::TDCC_SPI_RD) | cs_n_s;
        if (cs_n_s) begin
            next_spi_st  = tdcc_pkg::TDCC_SPI_OP;
            next_bit_cnt = 5'h00;
            next_miso    = 1'b0;
        end else if (sclk_rise) begin
            next_sh_in   = {sh_in[14:0], mosi_s};
            next_bit_cnt = bit_cnt + 5'h01;
            case (spi_st)
                tdcc_pkg::TDCC_SPI_OP: begin
                    if (next_bit_cnt == `TDCC_OP_BITS) begin
                        if (next_sh_in[7:0] == `TDCC_OP_WRITE) begin
                            next_spi_st = tdcc_pkg::TDCC_SPI_WR;
                        end else if (next_sh_in[7:0] == `TDCC_OP_READ) begin
                            next_spi_st = tdcc_pkg::TDCC_SPI_RD;
                            next_sh_out = ctrl & `TDCC_CTRL_MASK;
                        end else begin
                            next_spi_st = tdcc_pkg::TDCC_SPI_IGN;
                        end
                    end
                end
                tdcc_pkg::TDCC_SPI_WR: begin
                    if (next_bit_cnt == `TDCC_FRAME_BITS) begin
                        next_ctrl   = next_sh_in & `TDCC_CTRL_MASK;
                        next_spi_st = tdcc_pkg::TDCC_SPI_IGN;
                    end
                end
                tdcc_pkg::TDCC_SPI_RD: begin
                    if (next_bit_cnt == `TDCC_FRAME_BITS) begin
                        next_spi_st = tdcc_pkg::TDCC_SPI_IGN;
                    end
                end
                default: begin
                    next_spi_st = tdcc_pkg::TDCC_SPI_IGN;
                end
            endcase
        end else if (sclk_fall && spi_st == tdcc_pkg::TDCC_SPI_RD) begin
            next_miso   = sh_out[15];
            next_sh_out = {sh_out[14:0], 1'b0};
        end
    end
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ctrl          <= `TDCC_CTRL_RESET;
            spi_st        <= tdcc_pkg::TDCC_SPI_OP;
            bit_cnt       <= 5'h00;
            sh_in         <= 16'h0000;
            sh_out        <= 16'h0000;
            spi_miso      <= 1'b0;
            spi_miso_oe_n <= 1'b1;
            sclk_d        <= 1'b0;
            slow_d        <= 1'b0;
        end else begin
            ctrl          <= next_ctrl;
            spi_st        <= next_spi_st;
            bit_cnt       <= next_bit_cnt;
            sh_in         <= next_sh_in;
            sh_out        <= next_sh_out;
            spi_miso      <= next_miso;
            spi_miso_oe_n <= next_miso_oe_n;
            sclk_d        <= sclk_s;
            slow_d        <= slow_s;
        end
    end

    // ------------------------------------------------------------------
    // Monitor pin and event interrupt
    // ------------------------------------------------------------------
    logic irq_pend, next_irq_pend;
    logic next_mon, next_int_n, next_halt, event_irq;
    always_comb begin
        next_mon = 1'b0;
        if (ctrl.monitor_pin_enable) begin
            next_mon = ctrl.monitor_source_select ? cmp_s : dir_s;
        end
        // With continuous timing and no per-cycle interrupt the engine
        // raises nothing of its own; the host polls or stops it.
        event_irq = evt_running &
                    ((ctrl.per_cycle_irq & cycle_done) |
                     (~ctrl.per_cycle_irq &
                      ~ctrl.event_timing_continuous & seq_done));
        // A new event outranks a clear in the same cycle.
        next_irq_pend = event_irq | (irq_pend & ~irq_clear);
        next_int_n    = ~(ctrl.irq_pin_enable &
                          (next_irq_pend | irq_other));
        next_halt     = evt_running & seq_done &
                        ~ctrl.event_timing_continuous;
    end
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            monitor_out_pin <= 1'b0;
            irq_pend        <= 1'b0;
            int_n           <= 1'b1;
            evt_halt        <= 1'b0;
            evt_repeat      <= 1'b0;
        end else begin
            monitor_out_pin <= next_mon;
            irq_pend        <= next_irq_pend;
            int_n           <= next_int_n;
            evt_halt        <= next_halt;
            evt_repeat      <= next_ctrl.event_timing_continuous;
        end
    end

    // ------------------------------------------------------------------
    // Oscillator settle timer and calibration window
    // ------------------------------------------------------------------
    tdcc_pkg::tdcc_osc_t osc_st, next_osc_st;
    logic [7:0] settle_cnt, next_settle_cnt, settle_lim;
    logic       osc_cont, next_osc_en, next_osc_rdy;
    logic [3:0] cal_cnt, next_cal_cnt;
    logic       next_cal_win;
    always_comb begin
        osc_cont = ctrl.settle_sel >= `TDCC_SETTLE_CONT;
        case (ctrl.settle_sel)
            3'h0:    settle_lim = `TDCC_SETTLE_0;
            3'h1:    settle_lim = `TDCC_SETTLE_1;
            3'h2:    settle_lim = `TDCC_SETTLE_2;
            3'h3:    settle_lim = `TDCC_SETTLE_3;
            default: settle_lim = `TDCC_SETTLE_4;
        endcase
        next_osc_st     = osc_st;
        next_settle_cnt = settle_cnt;
        case (osc_st)
            tdcc_pkg::TDCC_OSC_OFF: begin
                next_settle_cnt = 8'h00;
                if (osc_request) begin
                    next_osc_st = osc_cont ? tdcc_pkg::TDCC_OSC_RUN
                                           : tdcc_pkg::TDCC_OSC_SETTLE;
                end
            end
            tdcc_pkg::TDCC_OSC_SETTLE: begin
                if (!osc_request) begin
                    next_osc_st = tdcc_pkg::TDCC_OSC_OFF;
                end else if (osc_cont) begin
                    next_osc_st = tdcc_pkg::TDCC_OSC_RUN;
                end else if (tick32) begin
                    next_settle_cnt = settle_cnt + 8'h01;
                    if (next_settle_cnt == settle_lim) begin
                        next_osc_st = tdcc_pkg::TDCC_OSC_RUN;
                    end
                end
            end
            tdcc_pkg::TDCC_OSC_RUN: begin
                if (!osc_request) begin
                    next_osc_st = tdcc_pkg::TDCC_OSC_OFF;
                end
            end
            default: begin
                next_osc_st = tdcc_pkg::TDCC_OSC_OFF;
            end
        endcase
        next_osc_en  = osc_cont | (next_osc_st != tdcc_pkg::TDCC_OSC_OFF);
        next_osc_rdy = next_osc_st == tdcc_pkg::TDCC_OSC_RUN;
        next_cal_win = cal_window;
        next_cal_cnt = cal_cnt;
        if (cal_start && !cal_window) begin
            next_cal_win = 1'b1;
            next_cal_cnt = 4'h0;
        end else if (cal_window && tick32) begin
            next_cal_cnt = cal_cnt + 4'h1;
            if (cal_cnt == ctrl.cal_span) begin
                next_cal_win = 1'b0;
            end
        end
    end
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            osc_st     <= tdcc_pkg::TDCC_OSC_OFF;
            settle_cnt <= 8'h00;
            osc_enable <= 1'b0;
            osc_ready  <= 1'b0;
            cal_cnt    <= 4'h0;
            cal_window <= 1'b0;
        end else begin
            osc_st     <= next_osc_st;
            settle_cnt <= next_settle_cnt;
            osc_enable <= next_osc_en;
            osc_ready  <= next_osc_rdy;
            cal_cnt    <= next_cal_cnt;
            cal_window <= next_cal_win;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    monitor_low_a: assert property (!ctrl.monitor_pin_enable |=>
        !monitor_out_pin) else $error("monitor pin not low while disabled");
    monitor_cmp_a: assert property (ctrl.monitor_pin_enable &&
        ctrl.monitor_source_select |=> monitor_out_pin == $past(cmp_s))
        else $error("monitor pin does not follow comparator");
    irq_blocked_a: assert property (!ctrl.irq_pin_enable |=> int_n)
        else $error("interrupt driven while pin disabled");
    irq_other_a: assert property (ctrl.irq_pin_enable && irq_other
        |=> !int_n) else $error("other source not seen on interrupt pin");
    cycle_irq_a: assert property (ctrl.irq_pin_enable && evt_running
        && ctrl.per_cycle_irq && cycle_done |=> !int_n)
        else $error("no interrupt after measurement cycle");
    seq_halt_a: assert property (evt_running && seq_done
        && !ctrl.event_timing_continuous |=> evt_halt
        ##1 (!evt_halt || $past(seq_done)))
        else $error("single sequence not halted");
    cont_quiet_a: assert property (ctrl.event_timing_continuous
        && !ctrl.per_cycle_irq && !irq_pend && !irq_other |=> int_n)
        else $error("continuous mode raised an event interrupt");
    osc_cont_a: assert property (osc_cont && osc_request
        |=> osc_ready && osc_enable)
        else $error("continuous oscillator not ready");
    settle_wait_a: assert property (!osc_cont &&
        osc_st == tdcc_pkg::TDCC_OSC_SETTLE |-> settle_cnt < settle_lim
        && !osc_ready) else $error("oscillator ready before settle count");
    cal_len_a: assert property (cal_window |->
        cal_cnt <= ctrl.cal_span)
        else $error("calibration window overran its span");
    wr_commit_a: assert property (spi_st == tdcc_pkg::TDCC_SPI_WR && sclk_rise
        && bit_cnt == (`TDCC_FRAME_BITS - 5'h01)
        |=> ctrl == ($past(next_sh_in) & `TDCC_CTRL_MASK))
        else $error("write frame not committed");
endmodule : tdcc_ctrl

// [tdcc_defines.svh]
// Opcodes, field positions, reset value and counts of the block.
`ifndef TDCC_DEFINES_SVH
`define TDCC_DEFINES_SVH

// ----------------------------------------------------------------------
// Serial access
// ----------------------------------------------------------------------
`define TDCC_OP_WRITE       8'h42
`define TDCC_OP_READ        8'hc2
`define TDCC_OP_BITS        5'h08
`define TDCC_FRAME_BITS     5'h18

// ----------------------------------------------------------------------
// Calibration and control register
// ----------------------------------------------------------------------
`define TDCC_CTRL_RESET     16'h0000
`define TDCC_CTRL_MASK      16'h0fff
`define TDCC_MON_EN_BIT     11
`define TDCC_MON_SEL_BIT    10
`define TDCC_IRQ_EN_BIT     9
`define TDCC_CONT_BIT       8
`define TDCC_PER_CYCLE_BIT  7
`define TDCC_SETTLE_MSB     6
`define TDCC_SETTLE_LSB     4
`define TDCC_SPAN_MSB       3
`define TDCC_SPAN_LSB       0

// ----------------------------------------------------------------------
// Oscillator settle counts, in 32.768 kHz periods
// ----------------------------------------------------------------------
`define TDCC_SETTLE_0       8'h10
`define TDCC_SETTLE_1       8'h30
`define TDCC_SETTLE_2       8'h60
`define TDCC_SETTLE_3       8'h80
`define TDCC_SETTLE_4       8'ha8
`define TDCC_SETTLE_CONT    3'h5

`endif

// [tdcc_host.sv]
// Host model that drives serial frames into the calibration register.
`timescale 1ns/1ps
module tdcc_host (
    input  wire logic mclk,
    output logic      spi_sclk,
    output logic      spi_cs_n,
    output logic      spi_mosi,
    input  wire logic spi_miso
);
    // Each serial phase lasts six system clocks, above the four required.
    localparam int HALF = 6;

    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end

    task automatic idle(input int n);
        repeat (n) @(negedge mclk);
    endtask : idle

    // The serial clock stands low outside frames. The data line is
    // inverted afterwards so that no stale bit can be mistaken for data.
    task automatic frame(input  logic [7:0]  op,
                         input  logic [15:0] din,
                         output logic [15:0] dout);
        logic [23:0] sh;
        sh = {op, din};
        dout = 16'h0000;
        @(negedge mclk);
        spi_cs_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            spi_mosi = sh[i];
            idle(HALF);
            if (i < 16) begin
                dout[i] = spi_miso;
            end
            spi_sclk = 1'b1;
            idle(HALF);
            spi_sclk = 1'b0;
        end
        idle(HALF);
        spi_cs_n = 1'b1;
        spi_mosi = ~spi_mosi;
        idle(HALF);
    endtask : frame
endmodule : tdcc_host

// [tdcc_pkg.sv]
// Types shared by the calibration and control block.
package tdcc_pkg;

    typedef struct packed {
        logic [3:0] reserved;
        logic       monitor_pin_enable;
        logic       monitor_source_select;
        logic       irq_pin_enable;
        logic       event_timing_continuous;
        logic       per_cycle_irq;
        logic [2:0] settle_sel;
        logic [3:0] cal_span;
    } tdcc_ctrl_t;

    typedef enum logic [1:0] {
        TDCC_SPI_OP  = 2'b00,
        TDCC_SPI_WR  = 2'b01,
        TDCC_SPI_RD  = 2'b11,
        TDCC_SPI_IGN = 2'b10
    } tdcc_spi_t;

    typedef enum logic [1:0] {
        TDCC_OSC_OFF    = 2'b00,
        TDCC_OSC_SETTLE = 2'b01,
        TDCC_OSC_RUN    = 2'b11
    } tdcc_osc_t;

endpackage : tdcc_pkg

// [tdcc_sync2.sv]
// Two-stage synchroniser for a bundle of asynchronous inputs.
`timescale 1ns/1ps
module tdcc_sync2 #(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] stage1;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            stage1 <= '0;
            q      <= '0;
        end else begin
            stage1 <= d;
            q      <= stage1;
        end
    end
endmodule : tdcc_sync2

// [test_tdcc_ctrl.sv]
// Self-checking testbench of the calibration and control block.
`include "tdcc_defines.svh"
`timescale 1ns/1ps
module test_tdcc_ctrl;
    logic mclk, nrst, spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe_n;
    logic clk32k, comparator_in, launch_dir_in, monitor_out_pin;
    logic evt_running, cycle_done, seq_done, irq_other, irq_clear, int_n;
    logic evt_halt, evt_repeat, osc_request, osc_enable, osc_ready;
    logic cal_start, cal_window;
    logic [15:0] q;
    logic        exp_mon;
    int          err_total, comparisons, halt_cnt;
    int          lens[5] = '{16, 48, 96, 128, 168};

    tdcc_ctrl dut_u (.mclk(mclk), .nrst(nrst), .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
        .spi_miso_oe_n(spi_miso_oe_n), .clk32k(clk32k),
        .comparator_in(comparator_in), .launch_dir_in(launch_dir_in),
        .monitor_out_pin(monitor_out_pin), .evt_running(evt_running),
        .cycle_done(cycle_done), .seq_done(seq_done),
        .irq_other(irq_other), .irq_clear(irq_clear), .int_n(int_n),
        .evt_halt(evt_halt), .evt_repeat(evt_repeat),
        .osc_request(osc_request), .osc_enable(osc_enable),
        .osc_ready(osc_ready), .cal_start(cal_start),
        .cal_window(cal_window));

    tdcc_host host_u (.mclk(mclk), .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso));

    initial mclk = 1'b0;
    always #4 mclk = ~mclk;

    // Halt is a one-cycle pulse, so it is counted at the falling edge,
    // where it has settled, rather than polled.
    always @(negedge mclk) begin
        if (evt_halt === 1'b1) halt_cnt++;
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask : cyc

    task automatic chk(input string w, input logic [15:0] e,
                       input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", w, e, g);
        end
    endtask : chk

    task automatic chk1(input string w, input logic e, input logic g);
        chk(w, {15'h0000, e}, {15'h0000, g});
    endtask : chk1

    task automatic wr(input logic [15:0] d);
        logic [15:0] dummy;
        host_u.frame(`TDCC_OP_WRITE, d, dummy);
        cyc(4);
    endtask : wr

    task automatic rd(output logic [15:0] d);
        host_u.frame(`TDCC_OP_READ, 16'h0000, d);
    endtask : rd

    task automatic ev(input logic c, input logic s);
        cycle_done = c;
        seq_done = s;
        cyc(1);
        cycle_done = 1'b0;
        seq_done = 1'b0;
        cyc(3);
    endtask : ev

    task automatic clr();
        irq_clear = 1'b1;
        cyc(1);
        irq_clear = 1'b0;
        cyc(2);
    endtask : clr

    task automatic pulse32();
        clk32k = 1'b1;
        cyc(4);
        clk32k = 1'b0;
        cyc(4);
    endtask : pulse32

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict

    // The full run needs about 11300 cycles; about nine times that is a hang.
    initial begin
        #800_000;
        err_total++;
        print_verdict();
    end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        {nrst, clk32k, comparator_in, launch_dir_in, evt_running} = '0;
        {cycle_done, seq_done, irq_other, irq_clear} = '0;
        {osc_request, cal_start, err_total, comparisons, halt_cnt} = '0;
        cyc(20);
        nrst = 1'b1;
        cyc(4);
        chk("reset outputs", 16'h00c0, {8'h00, spi_miso_oe_n, int_n,
            monitor_out_pin, evt_halt, evt_repeat, osc_enable, osc_ready,
            cal_window});
        rd(q);
        chk("register reset", `TDCC_CTRL_RESET, q);
        wr(16'hffff);
        rd(q);
        chk("reserved dropped", `TDCC_CTRL_MASK, q);
        chk1("miso released", 1'b1, spi_miso_oe_n);
        chk1("repeat set", 1'b1, evt_repeat);
        host_u.frame(8'h43, 16'h0000, q);
        rd(q);
        chk("foreign opcode", `TDCC_CTRL_MASK, q);
        $display("Test register access done");

        for (int m = 0; m < 4; m++) begin
            wr({4'h0, m[1], m[0], 10'h000});
            for (int v = 0; v < 4; v++) begin
                comparator_in = v[0];
                launch_dir_in = v[1];
                cyc(5);
                exp_mon = m[1] & (m[0] ? v[0] : v[1]);
                chk1("monitor", exp_mon, monitor_out_pin);
            end
        end
        $display("Test monitor pin done");

        evt_running = 1'b1;
        wr(16'h0280);
        ev(1'b1, 1'b0);
        chk1("cycle irq", 1'b0, int_n);
        {irq_clear, cycle_done} = 2'b11;
        cyc(1);
        {irq_clear, cycle_done} = 2'b00;
        cyc(2);
        chk1("set beats clear", 1'b0, int_n);
        clr();
        chk1("irq cleared", 1'b1, int_n);
        wr(16'h0200);
        ev(1'b1, 1'b0);
        chk1("no cycle irq", 1'b1, int_n);
        ev(1'b0, 1'b1);
        chk1("sequence irq", 1'b0, int_n);
        chk("halt pulses", 16'h0001, halt_cnt[15:0]);
        clr();
        wr(16'h0300);
        ev(1'b1, 1'b0);
        ev(1'b0, 1'b1);
        chk1("continuous quiet", 1'b1, int_n);
        chk("no halt", 16'h0001, halt_cnt[15:0]);
        wr(16'h0080);
        irq_other = 1'b1;
        ev(1'b1, 1'b0);
        chk1("pin disabled", 1'b1, int_n);
        clr();
        wr(16'h0200);
        cyc(2);
        chk1("other source", 1'b0, int_n);
        irq_other = 1'b0;
        clr();
        chk1("all cleared", 1'b1, int_n);
        $display("Test interrupt done");

        for (int c = 0; c < 5; c++) begin
            wr({9'h000, c[2:0], 4'h0});
            osc_request = 1'b1;
            cyc(2);
            chk1("osc enable", 1'b1, osc_enable);
            for (int i = 1; i < lens[c]; i++) pulse32();
            chk1("osc early", 1'b0, osc_ready);
            pulse32();
            cyc(2);
            chk1("osc ready", 1'b1, osc_ready);
            osc_request = 1'b0;
            cyc(2);
        end
        for (int c = 5; c < 8; c++) begin
            wr({9'h000, c[2:0], 4'h0});
            chk1("osc always on", 1'b1, osc_enable);
            osc_request = 1'b1;
            cyc(3);
            chk1("osc ready fast", 1'b1, osc_ready);
            osc_request = 1'b0;
            cyc(2);
        end
        $display("Test oscillator done");

        for (int s = 0; s < 16; s += 15) begin
            wr({12'h000, s[3:0]});
            cal_start = 1'b1;
            cyc(1);
            cal_start = 1'b0;
            repeat (s) pulse32();
            cyc(2);
            chk1("window held", 1'b1, cal_window);
            pulse32();
            cyc(2);
            chk1("window closed", 1'b0, cal_window);
        end
        $display("Test calibration done");
        print_verdict();
    end
endmodule : test_tdcc_ctrl
